/* File: rtl/adc_cfg_defines.svh */
`ifndef ADC_CFG_DEFINES_SVH
`define ADC_CFG_DEFINES_SVH

// Register indices; the byte address is four times the index.
`define IDX_OUTPUT_FORMAT 4'h1
`define IDX_OFFSET_ADJUST 4'h2
`define IDX_STATUS        4'h4

// Power-on contents of the two write-only registers.
`define OUTPUT_FORMAT_RESET 16'h02ff
`define OFFSET_ADJUST_RESET 16'h007f

// Synchroniser start level for pins whose power-on meaning is a one.
`define SYNC_RESET_HIGH 2'h3

// Output format field positions.
`define BIT_CLOCK_PHASE   11
`define BIT_DDR_DISABLE   10
`define BIT_SWING_SELECT  9
`define BIT_EDGE_DEMUX    8

// Offset adjust field positions.
`define OFS_MAG_HI 15
`define OFS_MAG_LO 8
`define BIT_OFS_SIGN 7

// Filler bits that the host writes as ones.
`define FORMAT_FILL_MASK 16'h00ff
`define OFFSET_FILL_MASK 16'h007f

`endif

/* File: rtl/adc_cfg_pkg.sv */
package adc_cfg_pkg;

	// Decoded settings that leave the block.
	typedef struct packed {
		logic       swing_std;
		logic       rising;
		logic       ddr;
		logic       demux;
		logic       phase_90;
		logic [7:0] ofs_mag;
		logic       ofs_neg;
		logic [8:0] ofs_code;
	} dec_t;

	// Register-side state of the top module.
	typedef struct packed {
		logic [15:0] fmt_word;
		logic [15:0] ofs_word;
		logic [31:0] rdata;
		logic [1:0]  ext_sync;
		logic [1:0]  swing_sync;
		logic [1:0]  edge_sync;
		logic        fmt_seen;
		logic        ofs_seen;
	} regs_t;

	// Layout of the status word seen by software.
	typedef struct packed {
		logic [25:0] zero;
		logic        ext_mode;
		logic        phase_90;
		logic        demux;
		logic        rising;
		logic        swing_std;
		logic        ddr;
	} status_t;

endpackage

/* File: rtl/adc_cfg_if.sv */
`timescale 1ns/1ps
interface adc_cfg_if;
	import adc_cfg_pkg::*;

	// Raw register words and synchronised pin levels.
	logic [15:0] fmt_word;
	logic [15:0] ofs_word;
	logic        ext_mode;
	logic        swing_pin;
	logic        edge_pin;
	// Registered decode results.
	dec_t        res;

	modport regs (output fmt_word, ofs_word, ext_mode, swing_pin, edge_pin, input res);
	modport decode (input fmt_word, ofs_word, ext_mode, swing_pin, edge_pin, output res);
endinterface

/* File: rtl/adc_cfg_decode.sv */
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"
module adc_cfg_decode
	import adc_cfg_pkg::*;
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Register side.
	adc_cfg_if.decode cfg
);

	dec_t res_q;
	dec_t res_d;

	// Turns register words and pins into the settings that steer the outputs.
	function automatic dec_t decode(input logic [15:0] c, input logic [15:0] o,
		input logic ext, input logic sp, input logic ep);
		dec_t r;
		r.ddr = !c[`BIT_DDR_DISABLE]; // [R11]
		r.swing_std = ext ? c[`BIT_SWING_SELECT] : sp; // [R01] [R02]
		r.rising = !r.ddr && (ext ? c[`BIT_EDGE_DEMUX] : ep); // [R03]
		r.demux = r.ddr && !c[`BIT_EDGE_DEMUX]; // [R04]
		r.phase_90 = c[`BIT_CLOCK_PHASE] && !(r.ddr && !r.demux); // [R05]
		r.ofs_mag = o[`OFS_MAG_HI:`OFS_MAG_LO]; // [R08]
		r.ofs_neg = o[`BIT_OFS_SIGN]; // [R09]
		r.ofs_code = r.ofs_neg ? 9'h000 - {1'b0, r.ofs_mag} : {1'b0, r.ofs_mag}; // [R09]
		return r;
	endfunction

	// Power-on settings, worked out once so that reset loads a plain constant.
	localparam dec_t RES_POR = decode(`OUTPUT_FORMAT_RESET, `OFFSET_ADJUST_RESET,
		1'b1, 1'b1, 1'b0);

	// One register stage keeps every output glitch free.
	always_comb
	begin
		res_d = decode(cfg.fmt_word, cfg.ofs_word, cfg.ext_mode, cfg.swing_pin, cfg.edge_pin);
	end

	// Reset shows the power-on settings as if the extended mode were in force.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			res_q <= RES_POR; // [R10]
		else
			res_q <= res_d;
	end

	assign cfg.res = res_q;

endmodule

/* File: rtl/adc_cfg_regs.sv */
// How it works
// [R01] Swing bit set selects standard LVDS amplitude, clear selects reduced; resets to one.
// [R02] In extended mode the swing register bit replaces the swing select pin.
// [R03] In SDR the edge bit picks rising (1) or falling (0) data edge.
// [R04] In DDR the edge bit set means non-demultiplexed, clear means demultiplexed.
// [R05] DDR with non-demultiplexed output forces 0 degree clock, ignoring 90 degree setting.
// [R06] Host writes ones into format bits 7:0 and offset bits 6:0.
// [R07] Host writes the format register only during power-up initialisation.
// [R08] Offset magnitude bits 15:8 map linearly, 00h zero up to FFh full.
// [R09] Offset bit 7 clear applies positive offset, set applies negative.
// [R10] After reset the offset magnitude and sign are zero.
// [R11] DDR disable bit clear gives double data rate, set gives single.
// [R12] Written values hold until the next write or reset; no readback.
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"
module adc_cfg_regs
	import adc_cfg_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// Clock and reset.
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave.
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Control pins from outside this clock domain.
	input  wire logic              extended_mode_pin,
	input  wire logic              swing_select_pin,
	input  wire logic              edge_select_pin,
	// Converter settings.
	output logic                   output_swing_select,
	output logic                   data_on_rising_edge,
	output logic                   ddr_active,
	output logic                   demux_active,
	output logic                   clock_phase_90,
	output logic      [7:0]        offset_magnitude,
	output logic                   offset_negative,
	output logic      [8:0]        offset_code
);

	// The index decode needs four index bits above the byte lanes.
	generate
		if (ADDR_W < 6)
		begin : g_addr_check
			$error("adc_cfg_regs needs ADDR_W of at least 6");
		end
	endgenerate

	adc_cfg_if cfg ();

	regs_t       st_q;
	regs_t       st_d;
	logic [2:0]  sel;
	logic        setup;
	logic        access;
	logic        wr_fmt;
	logic        wr_ofs;
	logic        unmapped;
	status_t     status;

	// One-hot register select: bit 0 format, bit 1 offset, bit 2 status.
	function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-3:0] idx;
		idx = a[ADDR_W-1:2];
		reg_sel = 3'h0;
		if (a[1:0] == 2'h0)
		begin
			reg_sel[0] = (idx == (ADDR_W-2)'(`IDX_OUTPUT_FORMAT));
			reg_sel[1] = (idx == (ADDR_W-2)'(`IDX_OFFSET_ADJUST));
			reg_sel[2] = (idx == (ADDR_W-2)'(`IDX_STATUS));
		end
	endfunction

	// Bus phases and strobes.
	assign sel      = reg_sel(paddr);
	assign setup    = psel && !penable;
	assign access   = psel && penable;
	assign unmapped = (sel == 3'h0);
	assign wr_fmt   = access && pwrite && sel[0];
	assign wr_ofs   = access && pwrite && sel[1];

	// The block answers every access in its first cycle; read data was latched at setup.
	assign pready  = 1'b1;
	assign pslverr = access && (unmapped || (pwrite && sel[2]));
	assign prdata  = st_q.rdata;

	// Status word reports the settings actually in force, not the raw registers.
	always_comb
	begin
		status           = '0;
		status.ext_mode  = st_q.ext_sync[1];
		status.phase_90  = cfg.res.phase_90;
		status.demux     = cfg.res.demux;
		status.rising    = cfg.res.rising;
		status.swing_std = cfg.res.swing_std;
		status.ddr       = cfg.res.ddr;
	end

	// Next state: pin synchronisers, read latch and register writes.
	always_comb
	begin
		st_d = st_q;
		st_d.ext_sync   = {st_q.ext_sync[0], extended_mode_pin};
		st_d.swing_sync = {st_q.swing_sync[0], swing_select_pin};
		st_d.edge_sync  = {st_q.edge_sync[0], edge_select_pin};
		if (setup)
		begin
			// Write-only registers read as zero so nothing leaks back.
			st_d.rdata = (sel[2] && !pwrite) ? status : 32'h0000_0000; // [R12]
		end
		if (wr_fmt)
		begin
			// Filler bits are stored as given; the host is trusted to send ones.
			st_d.fmt_word = pwdata[15:0]; // [R06] [R07]
			st_d.fmt_seen = 1'b1;
		end
		if (wr_ofs)
		begin
			st_d.ofs_word = pwdata[15:0]; // [R08] [R09]
			st_d.ofs_seen = 1'b1;
		end
	end

	// State register; words hold until rewritten or reset.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q            <= '0;
			st_q.fmt_word   <= `OUTPUT_FORMAT_RESET; // [R01] [R04] [R11]
			st_q.ofs_word   <= `OFFSET_ADJUST_RESET; // [R10]
			// Synchronisers start in extended mode with standard swing, as the decoder
			// does, so that release shows no brief step into pin mode.
			st_q.ext_sync   <= `SYNC_RESET_HIGH; // [R01]
			st_q.swing_sync <= `SYNC_RESET_HIGH;
		end
		else
		begin
			st_q <= st_d; // [R12]
		end
	end

	// Feed the decoder through the shared interface.
	assign cfg.fmt_word  = st_q.fmt_word;
	assign cfg.ofs_word  = st_q.ofs_word;
	assign cfg.ext_mode  = st_q.ext_sync[1]; // [R02]
	assign cfg.swing_pin = st_q.swing_sync[1];
	assign cfg.edge_pin  = st_q.edge_sync[1];

	adc_cfg_decode u_decode (
		.pclk    (pclk),
		.presetn (presetn),
		.cfg     (cfg)
	);

	// Settings come straight from the decoder's flip-flops.
	assign output_swing_select = cfg.res.swing_std;
	assign data_on_rising_edge = cfg.res.rising;
	assign ddr_active          = cfg.res.ddr;
	assign demux_active        = cfg.res.demux;
	assign clock_phase_90      = cfg.res.phase_90;
	assign offset_magnitude    = cfg.res.ofs_mag;
	assign offset_negative     = cfg.res.ofs_neg;
	assign offset_code         = cfg.res.ofs_code;

	// Checks below sample on pclk and stand down while reset is held.
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// A format write reaches the swing output two edges later in extended mode.
	a_swing_write: assert property ( // [R01]
		(wr_fmt && st_q.ext_sync[1]) ##1 st_q.ext_sync[1]
		|-> ##1 output_swing_select == $past(pwdata[`BIT_SWING_SELECT], 2))
		else $error("swing output does not follow the written bit");

	// Until the first format write the standard swing stays in force in extended mode.
	a_swing_power_on: assert property ( // [R01]
		(!st_q.fmt_seen && $past(st_q.ext_sync[1])) |-> output_swing_select)
		else $error("swing not standard after power on");

	// In normal mode the synchronised pin steers the swing.
	a_swing_pin_mode: assert property ( // [R02]
		$past(!st_q.ext_sync[1]) |-> output_swing_select == $past(st_q.swing_sync[1]))
		else $error("swing does not follow the pin in normal mode");

	// SDR edge choice comes from the register in extended mode.
	a_edge_sdr_reg: assert property ( // [R03]
		$past(st_q.ext_sync[1] && st_q.fmt_word[`BIT_DDR_DISABLE])
		|-> data_on_rising_edge == $past(st_q.fmt_word[`BIT_EDGE_DEMUX]))
		else $error("SDR edge does not follow the register");

	// SDR edge choice comes from the pin in normal mode.
	a_edge_sdr_pin: assert property ( // [R03]
		$past(!st_q.ext_sync[1] && st_q.fmt_word[`BIT_DDR_DISABLE])
		|-> data_on_rising_edge == $past(st_q.edge_sync[1]))
		else $error("SDR edge does not follow the pin");

	// In DDR the same bit chooses demultiplexing, inverted.
	a_demux_ddr: assert property ( // [R04]
		$past(!st_q.fmt_word[`BIT_DDR_DISABLE])
		|-> demux_active == !$past(st_q.fmt_word[`BIT_EDGE_DEMUX]))
		else $error("demux select wrong in DDR");

	// Non-demultiplexed DDR never shows the shifted clock.
	a_phase_forced: assert property ( // [R05]
		(ddr_active && !demux_active) |-> !clock_phase_90)
		else $error("90 degree phase active in non-demultiplexed DDR");

	// The mode bit selects double or single rate.
	a_ddr_mode: assert property ( // [R11]
		ddr_active == !$past(st_q.fmt_word[`BIT_DDR_DISABLE]))
		else $error("data rate does not follow the mode bit");

	// Offset magnitude written reaches the output two edges later.
	a_offset_mag: assert property ( // [R08]
		wr_ofs |-> ##2 offset_magnitude == $past(pwdata[`OFS_MAG_HI:`OFS_MAG_LO], 2))
		else $error("offset magnitude does not follow the write");

	// The signed code is the magnitude, negated when the sign is set.
	a_offset_sign: assert property ( // [R09]
		offset_negative ? (offset_code + {1'b0, offset_magnitude}) == 9'h000
		: offset_code == {1'b0, offset_magnitude})
		else $error("signed offset code inconsistent with sign");

	// No correction is applied before the host writes the offset.
	a_offset_por: assert property ( // [R10]
		!st_q.ofs_seen |-> (offset_code == 9'h000 && !offset_negative))
		else $error("offset applied before any write");

	// Held words change only at a write strobe.
	a_hold_words: assert property ( // [R12]
		(!wr_fmt && !wr_ofs) |=> ($stable(st_q.fmt_word) && $stable(st_q.ofs_word)))
		else $error("register word changed without a write");

	// Reads of the write-only registers return zero without error.
	a_no_readback: assert property ( // [R12]
		(access && !pwrite && (sel[0] || sel[1])) |-> (prdata == 32'h0000_0000 && !pslverr))
		else $error("write-only register read back");

	// A status read returns the word that stood in the setup cycle.
	a_status_read: assert property ( // [R12]
		(access && !pwrite && sel[2]) |-> prdata == $past(status))
		else $error("status read does not match the settings in force");

	// Writes to the status word are refused with an error.
	a_status_write_err: assert property ( // [R12]
		(access && pwrite && paddr == ADDR_W'(`IDX_STATUS * 4)) |-> pslverr)
		else $error("status write not refused");

	// No error is flagged outside the access phase.
	a_idle_no_err: assert property ( // [R12]
		!access |-> !pslverr)
		else $error("error flagged outside an access");

	// A format write lands in the held word at the write edge.
	a_fmt_write_lands: assert property ( // [R12]
		wr_fmt |=> st_q.fmt_word == $past(pwdata[15:0]))
		else $error("format word not taken from the write");

	// An offset write lands in the held word at the write edge.
	a_ofs_write_lands: assert property ( // [R12]
		wr_ofs |=> st_q.ofs_word == $past(pwdata[15:0]))
		else $error("offset word not taken from the write");

	// The edge choice has no meaning in double rate and stays low there.
	a_rising_ddr_low: assert property ( // [R03]
		ddr_active |-> !data_on_rising_edge)
		else $error("rising edge flagged in DDR");

	// Demultiplexing exists only in double rate.
	a_demux_sdr_low: assert property ( // [R04]
		!ddr_active |-> !demux_active)
		else $error("demux active in SDR");

	// Before the first format write the power-on DDR demultiplexed mode holds.
	a_format_por: assert property ( // [R04]
		!st_q.fmt_seen |-> (ddr_active && demux_active && !clock_phase_90))
		else $error("format settings not at power-on values");

	// The 90 degree setting takes effect wherever it is not forced off.
	a_phase_follow: assert property ( // [R05]
		($past(st_q.fmt_word[`BIT_CLOCK_PHASE]) && !(ddr_active && !demux_active))
		|-> clock_phase_90)
		else $error("90 degree phase setting lost");

	// The written sign reaches the output two edges later.
	a_offset_sign_write: assert property ( // [R09]
		wr_ofs |-> ##2 offset_negative == $past(pwdata[`BIT_OFS_SIGN], 2))
		else $error("offset sign does not follow the write");

	// A zero magnitude gives zero correction whatever the sign.
	a_offset_zero_code: assert property ( // [R08]
		(offset_magnitude == 8'h00) |-> (offset_code == 9'h000))
		else $error("zero magnitude gives nonzero offset");

	// Main scenarios.
	c_fmt_write: cover property (wr_fmt ##2 !ddr_active);
	c_neg_offset: cover property (wr_ofs ##2 offset_negative);
	c_nondemux_ddr: cover property (ddr_active && !demux_active);
	c_status_read: cover property (access && !pwrite && sel[2]);

endmodule

/* File: verification/adc_host_model.sv */
`timescale 1ns/1ps
module adc_host_model (
	// Clock.
	input  wire logic        pclk,
	// APB master side.
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// The bus is idle from time zero.
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// One transfer; the request stands until pready is seen high at an edge, or for at most 20 edges.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err, output logic hung);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		hung = (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		// A released data bus must not keep showing the old word.
		pwdata <= ~d;
	endtask

	// Register write; the filler bits always go out as ones.
	task automatic write_reg(input logic [7:0] a, input logic [15:0] v,
		output logic err, output logic hung);
		logic [31:0] rd;
		xfer(1'b1, a, {16'h0, v | ((a == 8'h04) ? 16'h00ff : 16'h007f)}, rd, err, hung);
	endtask
endmodule

/* File: verification/adc_output_and_offset_config_tb.sv */
`timescale 1ns/1ps
module adc_output_and_offset_config_tb;
	import adc_cfg_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr;
	logic        extended_mode_pin = 1'b1;
	logic        swing_select_pin = 1'b0;
	logic        edge_select_pin = 1'b1;
	logic        sw, rise, ddr, dmx, ph90, neg;
	logic [7:0]  mag;
	logic [8:0]  code;
	logic [22:0] outs, x;
	logic [15:0] f, o;
	logic [31:0] seed = 32'h1f;
	int          n_errors = 0;
	int          total_checks = 0;

	// Free-running clock.
	always #10 pclk = ~pclk;

	assign outs = {sw, rise, ddr, dmx, ph90, mag, neg, code};

	adc_cfg_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .extended_mode_pin(extended_mode_pin),
		.swing_select_pin(swing_select_pin), .edge_select_pin(edge_select_pin),
		.output_swing_select(sw), .data_on_rising_edge(rise), .ddr_active(ddr),
		.demux_active(dmx), .clock_phase_90(ph90), .offset_magnitude(mag),
		.offset_negative(neg), .offset_code(code));

	adc_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	// Settings expected from the two words, the mode and the pins.
	function automatic logic [22:0] expect_out(input logic [15:0] fw, input logic [15:0] ow,
		input logic e, input logic sp, input logic ep);
		logic d;
		d = ~fw[10];
		return {e ? fw[9] : sp, d ? 1'b0 : (e ? fw[8] : ep), d, d & ~fw[8],
			fw[11] & ~(d & fw[8]), ow[15:8], ow[7],
			ow[7] ? 9'h0 - {1'b0, ow[15:8]} : {1'b0, ow[15:8]}};
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task complete_run;
		if (n_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// One bus transfer with the expected error response.
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] v,
		input logic e);
		logic err;
		logic hung;
		if (w)
			host.write_reg(a, v, err, hung);
		else
			host.xfer(1'b0, a, 32'h0, rd, err, hung);
		if (hung)
		begin
			n_errors++;
			complete_run();
		end
		else
			check({31'h0, err}, {31'h0, e});
	endtask

	// Main sequence: reset, random settings, refusals, pin mode, second reset.
	initial
	begin
		repeat (5) @(posedge pclk);
		check(outs, expect_out(16'h02ff, 16'h007f, 1'b1, 1'b0, 1'b0));
		presetn <= 1'b1;
		// The first edges after release must still show the power-on settings.
		repeat (2) @(posedge pclk);
		check(outs, expect_out(16'h02ff, 16'h007f, 1'b1, 1'b0, 1'b0));
		repeat (2) @(posedge pclk);
		for (int i = 0; i < 24; i++)
		begin
			seed = xs(seed);
			f = {4'hb, (i < 16) ? i[3:0] : seed[3:0], 8'hff};
			o = {(i < 2) ? {8{~i[0]}} : seed[15:8], (i < 2) | seed[16], 7'h7f};
			swing_select_pin <= seed[20];
			edge_select_pin <= seed[21];
			bus(1'b1, 8'h04, f, 1'b0);
			bus(1'b1, 8'h08, o, 1'b0);
			// Read at the edge, so the pins below change on it and outputs are settled.
			repeat (2) @(posedge pclk);
			x = expect_out(f, o, 1'b1, 1'b0, 1'b0);
			check(outs, x);
			bus(1'b0, 8'h10, 16'h0, 1'b0);
			check(rd, {26'h0, 1'b1, x[18], x[19], x[21], x[22], x[20]});
		end
		bus(1'b0, 8'h04, 16'h0, 1'b0);
		check(rd, 32'h0);
		bus(1'b0, 8'h0c, 16'h0, 1'b1);
		bus(1'b1, 8'h10, 16'hffff, 1'b1);
		bus(1'b1, 8'h04, 16'hb4ff, 1'b0);
		for (int k = 0; k < 4; k++)
		begin
			@(posedge pclk);
			extended_mode_pin <= 1'b0;
			swing_select_pin <= k[0];
			edge_select_pin <= k[1];
			repeat (5) @(posedge pclk);
			#1;
			check(outs, expect_out(16'hb4ff, o, 1'b0, k[0], k[1]));
		end
		@(posedge pclk);
		presetn <= 1'b0;
		#1;
		check(outs, expect_out(16'h02ff, 16'h007f, 1'b1, 1'b0, 1'b0));
		@(posedge pclk);
		presetn <= 1'b1;
		// Mid-run release: power-on settings first, then the pins take over.
		repeat (2) @(posedge pclk);
		check(outs, expect_out(16'h02ff, 16'h007f, 1'b1, 1'b0, 1'b0));
		repeat (4) @(posedge pclk);
		check(outs, expect_out(16'h02ff, 16'h007f, 1'b0, 1'b1, 1'b1));
		bus(1'b0, 8'h10, 16'h0, 1'b0);
		check(rd, 32'h0000_000b);
		complete_run();
	end
endmodule
